// File: rtl/audt_pkg.sv
// Purpose: Shared constants, tables and types for the arithmetic option decode/timing block
// Assumes: pclk at 50 MHz, processor ring clock sampled as a level input
// Notes:   Decode tables are active low, Y1 in bit 7 and Y8 in bit 0
package audt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int PROC_CLK_NS      = 50;
  localparam int STEP_ADD_NS      = 400;
  localparam int STEP_SHIFT_NS    = 300;
  localparam int RING_TICKS_ADD   = STEP_ADD_NS / PROC_CLK_NS;
  localparam int RING_TICKS_SHIFT = STEP_SHIFT_NS / PROC_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and fields
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_IR      = 12'h008;
  localparam int          CTRL_MODE_A  = 0;
  localparam logic [11:0] IR_RESET     = 12'h000;
  localparam logic        MODE_RESET   = 1'b0;
  localparam logic [7:0]  ROM_OFF      = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  localparam logic [11:0] NEW_SET_CODE    = 12'hF19;
  localparam logic [11:0] LEGACY_SET_CODE = 12'hF27;
  localparam int          ROM_ADD_SEL_BIT = 6;
  localparam int          ROM_ADDR_INC_BIT = 2;
  localparam logic [3:0]  OP_MULTIPLY     = 4'h2;
  localparam logic [3:0]  OP_DVI          = 4'h3;
  localparam logic [3:0]  OP_DOUBLE_ADD   = 4'h9;
  localparam logic [3:0]  OP_DOUBLE_STORE = 4'hA;
  localparam logic [3:0]  OP_SUBTRACT     = 4'hF;
  localparam logic [4:0]  SC_LAST_MUL     = 5'h0B;
  localparam logic [4:0]  SC_LAST_DIV     = 5'h0C;
  localparam logic [4:0]  SC_LAST_ALL     = 5'h1F;
  localparam logic [1:0]  ADDER_B_PC      = 2'h0;
  localparam logic [1:0]  ADDER_B_MEM_DATA  = 2'h1;
  localparam logic [1:0]  ADDER_B_MULT_QUOT = 2'h2;
  localparam logic [1:0]  ADDER_B_PROC_ADDR = 2'h3;

  // Index {execute, instr bits 7..10}
  localparam logic [7:0] ROM1_TABLE [0:31] = '{
    8'hFF, 8'hFF, 8'hF9, 8'hFF, 8'h63, 8'hCF, 8'h79, 8'hF9,
    8'hFF, 8'hF9, 8'hFF, 8'hFF, 8'hF9, 8'h99, 8'h99, 8'hD9,
    8'hFF, 8'hFE, 8'hB7, 8'hA1, 8'hFF, 8'h62, 8'hF6, 8'hF6,
    8'hFF, 8'hD9, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Index {mode_b, instr bits 7..10}
  localparam logic [7:0] ROM2_TABLE [0:31] = '{
    8'hFF, 8'hFA, 8'hDA, 8'hDA, 8'hDF, 8'hFA, 8'hFA, 8'hFA,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h7F, 8'hD9, 8'hD9, 8'hDF, 8'hFA, 8'hFA, 8'hFA,
    8'hF7, 8'hF9, 8'hF9, 8'hFF, 8'hEF, 8'hBF, 8'hBF, 8'hBF};

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_RUN  = 3'b100
  } audt_state_t;

  typedef struct packed {
    logic fetch;
    logic execute;
    logic tp1;
    logic tp2;
    logic timing_pulse_2_delayed;
    logic timing_pulse_3;
    logic tp4;
    logic int_pending;
    logic data_break;
    logic clk20;
  } audt_ptiming_t;

  typedef struct packed {
    logic       bus_mult_quot;
    logic [1:0] adder_b;
  } audt_src_t;

endpackage

// File: rtl/audt_core.sv
// Purpose: Instruction capture, mode flag, decode ROMs and step timing ring
// Assumes: All processor inputs synchronous to pclk; APB register access
// Notes:   Ring advances on rising edges of the sampled 20 MHz processor clock
`timescale 1ns/10ps

// Operation
// RULE1 - Capture register holds 12 data bits loaded at fetch TP2, true and inverted
// RULE2 - Clear at TP4 for interrupt without data break, else at fetch TP1
// RULE3 - Mode resets to A; new-set picks B, legacy-set picks A
// RULE4 - Mode changes only at fetch TP2 trailing edge on option instruction; the code also forces A on an APB CTRL write with CTRL_MODE_A set
// RULE5 - First ROM enabled in fetch or execute for non-swap option instruction
// RULE6 - Second ROM enabled only in fetch for non-swap option instruction
// RULE7 - Each ROM takes a 5-bit address and yields an 8-bit command word
// RULE8 - ROM outputs are active low commands
// RULE9 - One second ROM output requests memory address plus one
// RULE10 - Multiply and divide give 331 in mode B, 332 in mode A
// RULE11 - Remaining second ROM fetch words follow the fixed octal table
// RULE12 - Four stage twisted ring; step pulse from stages two and three
// RULE13 - Each step pulse advances the step counter and clocks loads
// RULE14 - Shift only: stage one bypassed, six clocks, 300 ns step period
// RULE15 - Add select: stage one included, eight clocks, 400 ns step period
// RULE16 - Stop request asserted at delayed timing pulse 2; processor halts at timing pulse 3
// RULE17 - Timing pulse 3 leading edge sets the synchroniser starting the handover
// RULE18 - Ring starts on the next 20 MHz edge after running sets
// RULE19 - First step pulse follows stage four set with stage two reset
// RULE20 - Any terminate signal low clears synchroniser and restarts processor
// RULE21 - Bus picks accumulator or multiplier quotient; adder input picks data, quotient, PC, address
// RULE22 - Last step at count 13 multiply, 14 divide, 37 always
// RULE23 - Ring held reset while option timing is idle
module audt_core
  import audt_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire audt_ptiming_t ptiming,
  input  wire logic [11:0]   memory_data,
  input  wire logic [4:0]    step_count,
  input  wire logic          shift_ok,
  input  wire logic          double_term_n,
  output logic      [11:0]   instr_capture_reg,
  output logic      [11:0]   instr_capture_reg_n,
  output logic               mode_b,
  output logic      [7:0]    rom1_out_n,
  output logic      [7:0]    rom2_out_n,
  output logic               addr_increment_n,
  output logic               last_step_n,
  output audt_src_t          src_sel,
  output logic               step_pulse,
  output logic               processor_stop_req_n,
  output logic               option_running,
  output logic      [3:0]    ring_stages
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        sw_mode_a;
  logic        mode_ff;
  logic        esync_ff;
  logic        running_ff;
  logic        last_n_ff;
  logic [3:0]  ring_ff;
  logic [11:0] ir_ff;

  always_comb begin
    nxt_pready  = psel & ~penable & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata  = 32'h0000_0000;
    if (psel & ~penable) begin
      case (paddr)
        ADDR_CTRL:   nxt_prdata = 32'h0000_0000;
        ADDR_STATUS: nxt_prdata = {24'h00_0000, ring_ff, ~last_n_ff, running_ff,
                                   esync_ff, mode_ff};
        ADDR_IR:     nxt_prdata = {20'h0_0000, ir_ff};
        default:     nxt_pslverr = 1'b1;
      endcase
    end
    sw_mode_a = psel & penable & pready_ff & pwrite & (paddr == ADDR_CTRL)
                & pwdata[CTRL_MODE_A];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction capture, mode flag and decode ROMs
  logic        tp2_q_ff, pulse3_q_ff, clk20_q_ff;
  logic        tp2_rise, tp2_fall, pulse3_rise, clk_rise;
  logic [11:0] nxt_ir, nxt_ir_n, ir_n_ff;
  logic        nxt_mode;
  logic        is_option, is_swap, rom1_en, rom2_en;
  logic [3:0]  op;
  logic [7:0]  rom1_ff, rom2_ff, nxt_rom1, nxt_rom2;
  logic        addr_inc_ff, nxt_addr_inc, nxt_last_n;
  audt_src_t   src_ff, nxt_src;

  always_comb begin
    tp2_rise  = ptiming.tp2 & ~tp2_q_ff;
    tp2_fall  = ~ptiming.tp2 & tp2_q_ff;
    pulse3_rise = ptiming.timing_pulse_3 & ~pulse3_q_ff;
    clk_rise  = ptiming.clk20 & ~clk20_q_ff;
    op        = ir_ff[4:1];
    is_option = (ir_ff[11:9] == 3'h7) & ir_ff[8] & ir_ff[0];
    is_swap   = (ir_ff == NEW_SET_CODE) | (ir_ff == LEGACY_SET_CODE);
    rom1_en   = is_option & ~is_swap & (ptiming.fetch | ptiming.execute); // RULE5
    rom2_en   = is_option & ~is_swap & ptiming.fetch; // RULE6
    nxt_ir    = ir_ff;
    if (ptiming.int_pending & ~ptiming.data_break) begin
      if (ptiming.tp4) nxt_ir = IR_RESET; // RULE2
    end else if (ptiming.fetch & ptiming.tp1) begin
      nxt_ir = IR_RESET; // RULE2
    end
    if (ptiming.fetch & tp2_rise) nxt_ir = memory_data; // RULE1
    nxt_ir_n = ~nxt_ir; // RULE1
    nxt_mode = mode_ff;
    if (sw_mode_a) nxt_mode = 1'b0;
    if (ptiming.fetch & tp2_fall & is_option) begin // RULE4
      if (ir_ff == NEW_SET_CODE) nxt_mode = 1'b1; // RULE3
      else if (ir_ff == LEGACY_SET_CODE) nxt_mode = 1'b0; // RULE3
    end
    // Active low words from 5-bit addressed tables
    nxt_rom1 = rom1_en ? ROM1_TABLE[{ptiming.execute, op}] : ROM_OFF; // RULE7 RULE8
    nxt_rom2 = rom2_en ? ROM2_TABLE[{mode_ff, op}] : ROM_OFF; // RULE7 RULE10 RULE11
    nxt_addr_inc = nxt_rom2[ROM_ADDR_INC_BIT]; // RULE9
    nxt_last_n = ~((step_count == SC_LAST_ALL)
                 | (rom1_en & (op == OP_MULTIPLY) & (step_count == SC_LAST_MUL))
                 | (rom1_en & (op == OP_DVI) & (step_count == SC_LAST_DIV))); // RULE22
    nxt_src.bus_mult_quot = ptiming.execute & rom1_en
                            & ((op == OP_DOUBLE_ADD) | (op == OP_DOUBLE_STORE)); // RULE21
    if (~nxt_rom2[ROM_ADDR_INC_BIT]) nxt_src.adder_b = ADDER_B_PROC_ADDR; // RULE21
    else if (rom1_en & (op == OP_SUBTRACT)) nxt_src.adder_b = ADDER_B_MULT_QUOT;
    else if (rom1_en) nxt_src.adder_b = ADDER_B_MEM_DATA;
    else nxt_src.adder_b = ADDER_B_PC;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp2_q_ff    <= 1'b0;
      pulse3_q_ff <= 1'b0;
      clk20_q_ff  <= 1'b0;
      ir_ff       <= IR_RESET;
      ir_n_ff     <= ~IR_RESET;
      mode_ff     <= MODE_RESET;
      rom1_ff     <= ROM_OFF;
      rom2_ff     <= ROM_OFF;
      addr_inc_ff <= 1'b1;
      last_n_ff   <= 1'b1;
      src_ff      <= '0;
    end else begin
      tp2_q_ff    <= ptiming.tp2;
      pulse3_q_ff <= ptiming.timing_pulse_3;
      clk20_q_ff  <= ptiming.clk20;
      ir_ff       <= nxt_ir;
      ir_n_ff     <= nxt_ir_n; // RULE1
      mode_ff     <= nxt_mode;
      rom1_ff     <= nxt_rom1;
      rom2_ff     <= nxt_rom2;
      addr_inc_ff <= nxt_addr_inc; // RULE9
      last_n_ff   <= nxt_last_n;
      src_ff      <= nxt_src;
    end
  end

  assign instr_capture_reg   = ir_ff;
  assign instr_capture_reg_n = ir_n_ff;
  assign mode_b              = mode_ff;
  assign rom1_out_n          = rom1_ff;
  assign rom2_out_n          = rom2_ff;
  assign addr_increment_n    = addr_inc_ff;
  assign last_step_n         = last_n_ff;
  assign src_sel             = src_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Step timing ring and processor handover
  audt_state_t state_ff, nxt_state;
  logic [3:0]  nxt_ring;
  logic        armed_ff, nxt_armed;
  logic        pulse_ff, nxt_pulse;
  logic        stop_n_ff, nxt_stop_n;
  logic        need_run, add_sel, terminate;
  logic        nxt_esync, nxt_running;

  always_comb begin
    need_run   = ptiming.execute & (rom1_ff != ROM_OFF);
    add_sel    = ~rom1_ff[ROM_ADD_SEL_BIT];
    terminate  = ~last_n_ff | ~shift_ok | ~double_term_n;
    nxt_state  = state_ff;
    nxt_ring   = ring_ff;
    nxt_armed  = armed_ff;
    nxt_pulse  = 1'b0;
    nxt_stop_n = stop_n_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_ring  = 4'h0; // RULE23
        nxt_armed = 1'b0;
        if (need_run & ptiming.timing_pulse_2_delayed) nxt_stop_n = 1'b0; // RULE16
        if (~stop_n_ff & pulse3_rise) nxt_state = ST_SYNC; // RULE17
      end
      ST_SYNC: begin
        nxt_ring  = 4'h0;
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (clk_rise) begin // RULE18
          if (terminate) begin // RULE20
            nxt_state  = ST_IDLE;
            nxt_stop_n = 1'b1;
            nxt_ring   = 4'h0;
          end else begin
            if (add_sel) nxt_ring = {ring_ff[2:0], ~ring_ff[3]}; // RULE15
            else nxt_ring = {ring_ff[2:1], ~ring_ff[3], 1'b0}; // RULE14
            if (ring_ff[3] & ~ring_ff[1]) nxt_armed = 1'b1; // RULE19
            nxt_pulse = armed_ff & ~(ring_ff[1] & ring_ff[2])
                        & nxt_ring[1] & nxt_ring[2]; // RULE12 RULE13
          end
        end
      end
      default: begin
        nxt_state  = ST_IDLE;
        nxt_ring   = 4'h0;
        nxt_stop_n = 1'b1;
      end
    endcase
    nxt_esync   = (nxt_state != ST_IDLE); // RULE17
    nxt_running = (nxt_state == ST_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ST_IDLE;
      ring_ff    <= 4'h0;
      armed_ff   <= 1'b0;
      pulse_ff   <= 1'b0;
      stop_n_ff  <= 1'b1;
      esync_ff   <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      ring_ff    <= nxt_ring;
      armed_ff   <= nxt_armed;
      pulse_ff   <= nxt_pulse;
      stop_n_ff  <= nxt_stop_n;
      esync_ff   <= nxt_esync; // RULE17
      running_ff <= nxt_running;
    end
  end

  assign step_pulse           = pulse_ff;
  assign processor_stop_req_n = stop_n_ff;
  assign option_running       = running_ff;
  assign ring_stages          = ring_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_IR_LOAD: assert property (ptiming.fetch && tp2_rise |=> // RULE1
      ir_ff == $past(memory_data) && ir_n_ff == ~$past(memory_data))
    else $error("capture register did not load at fetch TP2");

  AST_IR_CLR: assert property (ptiming.int_pending && !ptiming.data_break && ptiming.tp4 // RULE2
      && !(ptiming.fetch && tp2_rise) |=> ir_ff == IR_RESET)
    else $error("capture register not cleared at TP4");

  AST_IR_CLR_FETCH: assert property (ptiming.fetch && ptiming.tp1 && !tp2_rise // RULE2
      && !(ptiming.int_pending && !ptiming.data_break) |=> ir_ff == IR_RESET)
    else $error("capture register not cleared at fetch TP1");

  AST_MODE_NEW: assert property (ptiming.fetch && tp2_fall && ir_ff == NEW_SET_CODE // RULE3
      |=> mode_ff)
    else $error("new set instruction did not select mode B");

  AST_MODE_HOLD: assert property (!(ptiming.fetch && tp2_fall) && !sw_mode_a // RULE4
      |=> $stable(mode_ff))
    else $error("mode flag changed outside fetch TP2 trailing edge");

  AST_ROM1_OFF: assert property (!ptiming.fetch && !ptiming.execute // RULE5
      |=> rom1_ff == ROM_OFF)
    else $error("first ROM active outside fetch and execute");

  AST_ROM2_OFF: assert property (!ptiming.fetch |=> rom2_ff == ROM_OFF) // RULE6
    else $error("second ROM active outside fetch");

  AST_ADDR_INC: assert property (addr_inc_ff == rom2_ff[ROM_ADDR_INC_BIT]) // RULE9
    else $error("address increment does not follow second ROM");

  AST_SRC_INC: assert property (!addr_inc_ff |-> src_ff.adder_b == ADDER_B_PROC_ADDR) // RULE21
    else $error("address increment without address source on adder");

  AST_STOP_REQ: assert property (state_ff == ST_IDLE && need_run // RULE16
      && ptiming.timing_pulse_2_delayed |=> !stop_n_ff)
    else $error("stop request not asserted at delayed timing pulse 2");

  AST_HANDOVER: assert property (state_ff == ST_IDLE && !stop_n_ff && pulse3_rise // RULE17
      |=> esync_ff ##1 running_ff)
    else $error("timing pulse 3 did not start the handover");

  AST_PULSE_STG: assert property (pulse_ff |-> ring_ff[1] && ring_ff[2] && armed_ff) // RULE12
    else $error("step pulse without stages two and three set");

  AST_SHIFT_RING: assert property (state_ff == ST_RUN && clk_rise && !add_sel // RULE14
      && !terminate |=> !ring_ff[0])
    else $error("stage one not bypassed in shift mode");

  AST_ADD_RING: assert property (state_ff == ST_RUN && clk_rise && add_sel && !terminate // RULE15
      && !ring_ff[3] |=> ring_ff[0])
    else $error("stage one not included in add mode");

  AST_TERMINATE: assert property (state_ff == ST_RUN && clk_rise && terminate // RULE20
      |=> state_ff == ST_IDLE && stop_n_ff ##1 !esync_ff)
    else $error("terminate did not end option timing");

  AST_LAST_ALL: assert property (step_count == SC_LAST_ALL |=> !last_n_ff) // RULE22
    else $error("last step missing at count 37");

  AST_RING_IDLE: assert property (state_ff == ST_IDLE [*2] |-> ring_ff == 4'h0) // RULE23
    else $error("ring not held reset while idle");

endmodule

// File: test/audt_proc_model.sv
// Purpose: Host processor timing model facing the option decode and timing block
// Assumes: Called from the bench through its tasks, one pclk per timing slot except fetch TP2, held two
// Notes:   20 MHz clock runs free, rising edges 2 and 3 pclk apart in turn
`timescale 1ns/10ps
module audt_proc_model
  import audt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        processor_stop_req_n,
  output audt_ptiming_t    ptiming,
  output logic      [11:0] memory_data
);
  audt_ptiming_t pt = '0;
  logic [2:0]    ph = 3'h0;

  initial memory_data = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Free running processor clock
  always @(posedge pclk) begin
    ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
  end

  always_comb begin
    ptiming = pt;
    ptiming.clk20 = (ph == 3'h0) || (ph == 3'h2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch cycle, left with fetch still high
  task automatic fetch(input logic [11:0] word);
    pt.fetch <= 1'b1;
    pt.tp1 <= 1'b1;
    @(posedge pclk);
    pt.tp1 <= 1'b0;
    pt.tp2 <= 1'b1;
    memory_data <= word;
    repeat (2) @(posedge pclk);
    pt.tp2 <= 1'b0;
    @(posedge pclk);
    memory_data <= ~word;
    pt.timing_pulse_3 <= 1'b1;
    @(posedge pclk);
    pt.timing_pulse_3 <= 1'b0;
    pt.tp4 <= 1'b1;
    @(posedge pclk);
    pt.tp4 <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic tp4_pulse(input logic ip, input logic db);
    pt.int_pending <= ip;
    pt.data_break <= db;
    pt.tp4 <= 1'b1;
    @(posedge pclk);
    pt.tp4 <= 1'b0;
    pt.int_pending <= 1'b0;
    pt.data_break <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Execute cycle, halting at timing pulse 3 while the stop request stands
  task automatic exec_run(output int stopped);
    int n;
    stopped = 0;
    n = 0;
    pt.fetch <= 1'b0;
    pt.execute <= 1'b1;
    pt.tp1 <= 1'b1;
    @(posedge pclk);
    pt.tp1 <= 1'b0;
    pt.tp2 <= 1'b1;
    @(posedge pclk);
    pt.tp2 <= 1'b0;
    pt.timing_pulse_2_delayed <= 1'b1;
    @(posedge pclk);
    pt.timing_pulse_2_delayed <= 1'b0;
    @(posedge pclk);
    if (processor_stop_req_n === 1'b0) stopped = 1;
    pt.timing_pulse_3 <= 1'b1;
    @(posedge pclk);
    pt.timing_pulse_3 <= 1'b0;
    while (stopped == 1 && processor_stop_req_n !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    pt.tp4 <= 1'b1;
    @(posedge pclk);
    pt.tp4 <= 1'b0;
    pt.execute <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// File: test/arith_unit_decode_and_timing_tb.sv
// Purpose: Self-checking bench for the option decode and timing block
// Assumes: Bench acts as step counter and APB master, model as processor
// Notes:   Step spacing measured in pclk cycles, 20 for add and 15 for shift
`timescale 1ns/10ps
module arith_unit_decode_and_timing_tb
  import audt_pkg::*;
;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  audt_ptiming_t ptiming;
  logic [11:0]   memory_data;
  logic [4:0]    step_count = 5'h00;
  logic          shift_ok = 1'b1;
  logic          double_term_n = 1'b1;
  logic [11:0]   ir;
  logic [11:0]   ir_n;
  logic          mode_b;
  logic [7:0]    rom1_n;
  logic [7:0]    rom2_n;
  logic          inc_n;
  logic          step_pulse;
  logic          stop_n;
  logic          running;
  logic [3:0]    ring;
  logic          last_n;
  audt_src_t     src;
  logic          sc_load = 1'b0;
  logic [4:0]    sc_init = 5'h00;
  int            term_sel = 0;
  int            kill_at = 0;
  int            cyc = 0;
  int            last = 0;
  int            npulse = 0;
  int            gmin = 0;
  int            gmax = 0;
  logic          seen_run = 1'b0;
  int            errors = 0;
  int            cmp_count = 0;
  logic [31:0]   rd;
  logic          er;
  logic [7:0]    rom_b [0:15] = '{8'hFF, 8'h7F, 8'hD9, 8'hD9, 8'hDF, 8'hFA, 8'hFA, 8'hFA,
                                  8'hF7, 8'hF9, 8'hF9, 8'hFF, 8'hEF, 8'hBF, 8'hBF, 8'hBF};
  logic [7:0]    rom_a [0:3] = '{8'hFF, 8'hFA, 8'hDA, 8'hDA};

  always #10 pclk = ~pclk;

  audt_core audt_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ptiming(ptiming), .memory_data(memory_data), .step_count(step_count),
    .shift_ok(shift_ok), .double_term_n(double_term_n), .instr_capture_reg(ir),
    .instr_capture_reg_n(ir_n), .mode_b(mode_b), .rom1_out_n(rom1_n), .rom2_out_n(rom2_n),
    .addr_increment_n(inc_n), .last_step_n(last_n), .src_sel(src), .step_pulse(step_pulse),
    .processor_stop_req_n(stop_n), .option_running(running), .ring_stages(ring));

  audt_proc_model audt_proc_model_i (
    .pclk(pclk), .processor_stop_req_n(stop_n), .ptiming(ptiming),
    .memory_data(memory_data));

  ////////////////////////////////////////////////////////////////////////////
  // Step counter and step spacing monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sc_load) begin
      step_count <= sc_init;
      npulse <= 0;
      gmin <= 999;
      gmax <= 0;
      shift_ok <= 1'b1;
      double_term_n <= 1'b1;
      seen_run <= 1'b0;
    end else begin
      if (running === 1'b1) seen_run <= 1'b1;
      if (step_pulse === 1'b1) begin
        step_count <= step_count + 5'h01;
        npulse <= npulse + 1;
        last <= cyc;
        if (npulse > 0 && cyc - last < gmin) gmin <= cyc - last;
        if (npulse > 0 && cyc - last > gmax) gmax <= cyc - last;
        if (npulse + 1 == kill_at && term_sel == 1) shift_ok <= 1'b0;
        if (npulse + 1 == kill_at && term_sel == 2) double_term_n <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic run_op(input logic [11:0] w, input logic [4:0] init, input int ts,
                        input int kill, input logic [4:0] expc, input int gap);
    int ok;
    audt_proc_model_i.fetch(w);
    sc_init <= init;
    term_sel <= ts;
    kill_at <= kill;
    sc_load <= 1'b1;
    @(posedge pclk);
    sc_load <= 1'b0;
    audt_proc_model_i.exec_run(ok);
    repeat (3) @(posedge pclk);
    chk("stop request", 32'(gap != 999), ok);
    chk("running seen", 32'(gap != 999), seen_run);
    chk("final count", expc, step_count);
    chk("last step", 32'(expc != 5'h1F), last_n);
    chk("gap min", gap, gmin);
    chk("gap max", (gap == 999) ? 0 : gap, gmax);
    chk("ring idle", 32'h0, ring);
    chk("running off", 32'h0, {running, ~stop_n});
    chk("rom2 off", 32'hFF, rom2_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ir reset", 32'h000, ir);
    chk("ir_n reset", 32'hFFF, ir_n);
    chk("mode reset", 32'h0, mode_b);
    chk("roms reset", 32'hFFFF, {rom1_n, rom2_n});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    audt_proc_model_i.fetch(12'hA5C);
    chk("ir load", 32'hA5C, ir);
    chk("ir_n load", 32'h5A3, ir_n);
    chk("rom1 plain", 32'hFF, rom1_n);
    apb(1'b0, ADDR_IR, 32'h0);
    chk("ir read", 32'hA5C, rd);
    audt_proc_model_i.tp4_pulse(1'b1, 1'b1);
    chk("ir kept", 32'hA5C, ir);
    audt_proc_model_i.tp4_pulse(1'b1, 1'b0);
    chk("ir clear", 32'h000, ir);
    audt_proc_model_i.fetch(NEW_SET_CODE);
    chk("mode new", 32'h1, mode_b);
    chk("swap roms", 32'hFFFF, {rom1_n, rom2_n});
    for (int op = 0; op < 16; op++) begin
      audt_proc_model_i.fetch(12'hF41 | 12'(op << 1));
      chk("rom2 b", rom_b[op], rom2_n);
      chk("inc b", rom_b[op][2], inc_n);
      chk("adder src", 32'(!rom_b[op][2]), 32'(src.adder_b == ADDER_B_PROC_ADDR));
    end
    chk("rom1 fetch", 32'hD9, rom1_n);
    audt_proc_model_i.fetch(LEGACY_SET_CODE);
    chk("mode legacy", 32'h0, mode_b);
    for (int op = 0; op < 4; op++) begin
      audt_proc_model_i.fetch(12'hF41 | 12'(op << 1));
      chk("rom2 a", rom_a[op], rom2_n);
      chk("inc a", rom_a[op][2], inc_n);
    end
    audt_proc_model_i.fetch(NEW_SET_CODE);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ctrl mode a", 32'h0, rd[0]);
    audt_proc_model_i.fetch(12'hF41);
    run_op(12'hF41, 5'h00, 0, 0, 5'h00, 999);
    run_op(12'hF45, 5'h00, 0, 0, 5'h0B, 20);
    run_op(12'hF47, 5'h00, 0, 0, 5'h0C, 20);
    run_op(12'hF4B, 5'h1A, 0, 0, 5'h1F, 15);
    run_op(12'hF4B, 5'h00, 1, 3, 5'h03, 15);
    run_op(12'hF4B, 5'h00, 2, 2, 5'h02, 15);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim;
  end
endmodule
